// ==== mmi_interp.sv ====
// MIDI message interpreter: receive parser, automix sync, bulk dump framing and transmit formatter
`timescale 1ns/100ps
`include "mmi_cfg.svh"
// Contract
// - Note-on on receive channel; velocity zero is off
// - Control change gated by enable, channel, any-channel; echo
// - Table mode maps controllers 0-95, 102-119
// - NRPN: 62h, 63h, 26h, 06h sequence
// - Repeated status bytes optional but accepted
// - Data MSB may be omitted for 7-bit values
// - Operated parameter sends control change on transmit channel
// - Program change recalls mapped scene, optional echo
// - Scene recall sends lowest mapped program number
// - Song position relocates automix, LSB first
// - Timing clock syncs automix and drives effects
// - Start/continue arm; run on next clock
// - Stop halts; transport ignored without MIDI clock
// - 400 ms silence after sensing resets receive
// - System reset clears receive state
// - Bulk frame field order and sub-status
// - Count is high times 128 plus low
// - Checksum is negated sum, bit 7 clear
// - Bulk accepted on enable and channel match
// - Requests answered on receive, panel on transmit channel
// - Payload packs seven bytes into eight
// - Scenes 0-99 and 256; setup fixed number
module mmi_interp #(
	parameter int SENSE_CYCLES = `MMI_SENSE_CYCLES,
	parameter logic [7:0] MFR_CODE = 8'h3A, // Arbitrary value
	parameter logic [63:0] MODEL_ID = 64'h0102_0304_0506_0708 // Arbitrary value
) (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_B_IN,
	// MIDI byte streams
	input wire logic [7:0] RX_BYTE_IN,
	input wire logic RX_VALID_IN,
	output logic [7:0] TX_BYTE_OUT,
	output logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	// Configuration
	input wire logic [3:0] RECEIVE_CHANNEL_IN,
	input wire logic [3:0] TRANSMIT_CHANNEL_IN,
	input wire logic ANY_CHANNEL_ACCEPT_IN,
	input wire logic CC_RX_EN_IN,
	input wire logic CC_TX_EN_IN,
	input wire logic CC_ECHO_IN,
	input wire logic CC_NRPN_MODE_IN,
	input wire logic PC_RX_EN_IN,
	input wire logic PC_TX_EN_IN,
	input wire logic PC_ECHO_IN,
	input wire logic BULK_RX_EN_IN,
	input wire logic TIME_REF_MIDI_IN,
	// Console side requests
	input wire logic PARAM_OP_IN,
	input wire mmi_pkg::mmi_param_s PARAM_OP_DATA_IN,
	output logic PARAM_OP_READY_OUT,
	input wire logic SCENE_RECALLED_IN,
	input wire logic [6:0] SCENE_RECALLED_NUM_IN,
	input wire logic PCT_WR_IN,
	input wire logic [6:0] PCT_PROG_IN,
	input wire logic [6:0] PCT_SCENE_IN,
	input wire logic PANEL_DUMP_IN,
	input wire logic [6:0] PANEL_DUMP_KIND_IN,
	input wire logic [13:0] PANEL_DUMP_NUM_IN,
	// Received events
	output logic NOTE_VALID_OUT,
	output mmi_pkg::mmi_note_s NOTE_OUT,
	output logic PARAM_VALID_OUT,
	output mmi_pkg::mmi_param_s PARAM_OUT,
	output logic SCENE_RECALL_OUT,
	output logic [6:0] SCENE_OUT,
	output logic CLOCK_TICK_OUT,
	output logic RELOCATE_OUT,
	output logic [13:0] SONG_POS_OUT,
	output logic AUTOMIX_START_OUT,
	output logic AUTOMIX_REWIND_OUT,
	output logic AUTOMIX_RUN_OUT,
	output logic SENSE_TIMEOUT_OUT,
	// Bulk dump
	output logic DUMP_WR_VALID_OUT,
	output mmi_pkg::mmi_dump_wr_s DUMP_WR_OUT,
	output logic DUMP_DONE_OUT,
	output logic DUMP_BAD_OUT,
	output logic DUMP_SEND_OUT,
	output mmi_pkg::mmi_dump_req_s DUMP_SEND_REQ_OUT
);
	import mmi_pkg::*;

	// ====
	// Byte classification
	logic [6:0] pc_table [128];
	logic rx_clear;
	logic [7:0] run_status;
	logic data_phase;
	logic [6:0] d1;
	logic sense_armed;
	logic [31:0] sense_cnt;
	logic sense_expire;
	logic is_rt, is_stat, is_data, msg_fin, ch_ok, any_ok;
	logic [6:0] m1, m2;
	assign is_rt = RX_VALID_IN && (RX_BYTE_IN >= `MMI_B_CLOCK);
	assign is_stat = RX_VALID_IN && RX_BYTE_IN[7] && !is_rt;
	assign is_data = RX_VALID_IN && !RX_BYTE_IN[7];
	assign sense_expire = sense_armed && (sense_cnt >= 32'(SENSE_CYCLES - 1));
	assign msg_fin = is_data && run_status[7] && (data_phase || run_status[7:4] == `MMI_ST_PROG
		|| run_status[7:4] == `MMI_ST_CHPRESS);
	assign m1 = data_phase ? d1 : RX_BYTE_IN[6:0];
	assign m2 = RX_BYTE_IN[6:0];
	assign ch_ok = run_status[3:0] == RECEIVE_CHANNEL_IN;
	assign any_ok = ch_ok || ANY_CHANNEL_ACCEPT_IN;
	assign rx_clear = !RST_B_IN || sense_expire || (is_rt && RX_BYTE_IN == `MMI_B_RESET);

	// ====
	// Running status and data assembly
	mmi_sx_e sx_state;
	always_ff @(posedge CORE_CLK_IN) begin
		if (rx_clear) begin
			run_status <= 8'h00;
			data_phase <= 1'b0;
			d1 <= 7'h00;
		end else if (is_stat) begin
			// Any non-realtime status byte other than channel or song position drops running status
			run_status <= (RX_BYTE_IN < `MMI_B_SYSEX || RX_BYTE_IN == `MMI_B_SONGPOS) ? RX_BYTE_IN : 8'h00;
			data_phase <= 1'b0;
		end else if (is_data && sx_state == SX_IDLE && run_status[7]) begin
			d1 <= RX_BYTE_IN[6:0];
			data_phase <= !msg_fin && !data_phase;
			if (msg_fin && run_status == `MMI_B_SONGPOS)
				run_status <= 8'h00;
		end
	end

	// ====
	// Channel message decode
	logic [13:0] nrpn_num;
	logic [6:0] nrpn_lsb;
	logic echo_pend;
	logic [23:0] echo_msg;
	logic [1:0] echo_len;
	logic tx_idle;
	logic fin_ok;
	assign fin_ok = msg_fin && sx_state == SX_IDLE;
	always_ff @(posedge CORE_CLK_IN) begin
		NOTE_VALID_OUT <= 1'b0;
		PARAM_VALID_OUT <= 1'b0;
		SCENE_RECALL_OUT <= 1'b0;
		if (!RST_B_IN) begin
			NOTE_OUT <= '0;
			PARAM_OUT <= '0;
			SCENE_OUT <= 7'h00;
			nrpn_num <= 14'h0000;
			nrpn_lsb <= 7'h00;
		end else if (fin_ok) begin
			case (run_status[7:4])
				`MMI_ST_NOTE_ON, `MMI_ST_NOTE_OFF: begin
					if (ch_ok) begin
						NOTE_VALID_OUT <= 1'b1;
						NOTE_OUT <= '{on: run_status[4] && m2 != 7'h00, note: m1, velocity: m2};
					end
				end
				`MMI_ST_CTRL: begin
					if (CC_RX_EN_IN && any_ok) begin
						if (!CC_NRPN_MODE_IN) begin
							if (m1 <= `MMI_CC_TAB_LO_MAX || (m1 >= `MMI_CC_TAB_HI_MIN && m1 <= `MMI_CC_TAB_HI_MAX)) begin
								PARAM_VALID_OUT <= 1'b1;
								PARAM_OUT <= '{nrpn: 1'b0, number: {7'h00, m1}, value: {7'h00, m2}};
							end
						end else if (m1 == `MMI_CC_NRPN_LSB) begin
							nrpn_num[6:0] <= m2;
						end else if (m1 == `MMI_CC_NRPN_MSB) begin
							nrpn_num[13:7] <= m2;
						end else if (m1 == `MMI_CC_DATA_LSB) begin
							// Applied at once as a 7-bit value since the MSB may never come
							nrpn_lsb <= m2;
							PARAM_VALID_OUT <= 1'b1;
							PARAM_OUT <= '{nrpn: 1'b1, number: nrpn_num, value: {7'h00, m2}};
						end else if (m1 == `MMI_CC_DATA_MSB) begin
							PARAM_VALID_OUT <= 1'b1;
							PARAM_OUT <= '{nrpn: 1'b1, number: nrpn_num, value: {m2, nrpn_lsb}};
						end
					end
				end
				`MMI_ST_PROG: begin
					if (PC_RX_EN_IN && any_ok) begin
						SCENE_RECALL_OUT <= 1'b1;
						SCENE_OUT <= pc_table[m1];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Echo slot: one message deep, a newer echo replaces one still waiting
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			echo_pend <= 1'b0;
			echo_msg <= 24'h0000_00;
			echo_len <= 2'h0;
		end else if (fin_ok && any_ok && ((run_status[7:4] == `MMI_ST_CTRL && CC_RX_EN_IN && CC_ECHO_IN)
			|| (run_status[7:4] == `MMI_ST_PROG && PC_RX_EN_IN && PC_ECHO_IN))) begin
			echo_pend <= 1'b1;
			echo_msg <= {run_status, 1'b0, m1, data_phase ? {1'b0, m2} : 8'h00};
			echo_len <= data_phase ? 2'h3 : 2'h2;
		end else if (tx_idle) begin
			echo_pend <= 1'b0;
		end
	end

	// ====
	// Program change table and lowest-program search
	logic scan_on, pc_pend;
	logic [6:0] scan_i, scan_scene, pc_prog;
	always_ff @(posedge CORE_CLK_IN) begin
		if (PCT_WR_IN)
			pc_table[PCT_PROG_IN] <= PCT_SCENE_IN;
	end
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			scan_on <= 1'b0;
			scan_i <= 7'h00;
			scan_scene <= 7'h00;
			pc_pend <= 1'b0;
			pc_prog <= 7'h00;
		end else if (SCENE_RECALLED_IN && PC_TX_EN_IN) begin
			scan_on <= 1'b1;
			scan_i <= 7'h00;
			scan_scene <= SCENE_RECALLED_NUM_IN;
		end else if (scan_on) begin
			// Scanning upward makes the first hit the lowest program
			if (pc_table[scan_i] == scan_scene) begin
				scan_on <= 1'b0;
				pc_pend <= 1'b1;
				pc_prog <= scan_i;
			end else begin
				scan_on <= scan_i != 7'h7F;
				scan_i <= scan_i + 7'h01;
			end
		end else if (tx_idle && !echo_pend) begin
			pc_pend <= 1'b0;
		end
	end

	// ====
	// Transmit formatter: running status is used, so follow-on status bytes are omitted
	mmi_param_s opd;
	assign opd = PARAM_OP_DATA_IN;
	logic [71:0] tx_shift;
	logic [3:0] tx_left;
	logic [3:0] tch;
	logic wide;
	assign tx_idle = tx_left == 4'h0;
	assign tch = TRANSMIT_CHANNEL_IN;
	assign wide = opd.value[13:7] != 7'h00;
	assign PARAM_OP_READY_OUT = tx_idle && !echo_pend && !pc_pend;
	assign TX_VALID_OUT = !tx_idle;
	assign TX_BYTE_OUT = tx_shift[71:64];
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN) begin
			tx_shift <= '0;
			tx_left <= 4'h0;
		end else if (!tx_idle) begin
			if (TX_READY_IN) begin
				tx_shift <= {tx_shift[63:0], 8'h00};
				tx_left <= tx_left - 4'h1;
			end
		end else if (echo_pend) begin
			tx_shift <= {echo_msg, 48'h0};
			tx_left <= {2'b00, echo_len};
		end else if (pc_pend) begin
			tx_shift <= {`MMI_ST_PROG, tch, 1'b0, pc_prog, 56'h0};
			tx_left <= 4'h2;
		end else if (PARAM_OP_IN && CC_TX_EN_IN) begin
			if (!CC_NRPN_MODE_IN) begin
				tx_shift <= {`MMI_ST_CTRL, tch, 1'b0, opd.number[6:0], 1'b0, opd.value[6:0], 48'h0};
				tx_left <= 4'h3;
			end else begin
				tx_shift <= {`MMI_ST_CTRL, tch, 1'b0, `MMI_CC_NRPN_LSB, 1'b0, opd.number[6:0],
					1'b0, `MMI_CC_NRPN_MSB, 1'b0, opd.number[13:7], 1'b0, `MMI_CC_DATA_LSB,
					1'b0, opd.value[6:0], 1'b0, `MMI_CC_DATA_MSB, 1'b0, opd.value[13:7]};
				tx_left <= wide ? 4'h9 : 4'h7;
			end
		end
	end

	// ====
	// Automix transport, song position and timing clock
	logic am_armed, am_rewind;
	always_ff @(posedge CORE_CLK_IN) begin
		CLOCK_TICK_OUT <= 1'b0;
		AUTOMIX_START_OUT <= 1'b0;
		RELOCATE_OUT <= 1'b0;
		if (!RST_B_IN) begin
			am_armed <= 1'b0;
			am_rewind <= 1'b0;
			AUTOMIX_RUN_OUT <= 1'b0;
			AUTOMIX_REWIND_OUT <= 1'b0;
			SONG_POS_OUT <= 14'h0000;
		end else if (is_rt) begin
			if (RX_BYTE_IN == `MMI_B_CLOCK) begin
				CLOCK_TICK_OUT <= 1'b1;
				if (am_armed && TIME_REF_MIDI_IN) begin
					am_armed <= 1'b0;
					AUTOMIX_RUN_OUT <= 1'b1;
					AUTOMIX_START_OUT <= 1'b1;
					AUTOMIX_REWIND_OUT <= am_rewind;
				end
			end else if (TIME_REF_MIDI_IN && (RX_BYTE_IN == `MMI_B_START || RX_BYTE_IN == `MMI_B_CONT)) begin
				am_armed <= 1'b1;
				am_rewind <= RX_BYTE_IN == `MMI_B_START;
			end else if (TIME_REF_MIDI_IN && RX_BYTE_IN == `MMI_B_STOP) begin
				am_armed <= 1'b0;
				AUTOMIX_RUN_OUT <= 1'b0;
			end
		end else if (fin_ok && run_status == `MMI_B_SONGPOS && TIME_REF_MIDI_IN) begin
			RELOCATE_OUT <= 1'b1;
			SONG_POS_OUT <= {m2, m1};
		end
	end

	// ====
	// Active sensing watchdog: any received byte restarts it
	always_ff @(posedge CORE_CLK_IN) begin
		SENSE_TIMEOUT_OUT <= 1'b0;
		if (!RST_B_IN) begin
			sense_armed <= 1'b0;
			sense_cnt <= 32'h0000_0000;
		end else if (RX_VALID_IN) begin
			sense_cnt <= 32'h0000_0000;
			if (RX_BYTE_IN == `MMI_B_SENSE)
				sense_armed <= 1'b1;
		end else if (sense_expire) begin
			sense_armed <= 1'b0;
			sense_cnt <= 32'h0000_0000;
			SENSE_TIMEOUT_OUT <= 1'b1;
		end else if (sense_armed) begin
			sense_cnt <= sense_cnt + 32'h0000_0001;
		end
	end

	// ====
	// Bulk dump receive
	logic sx_req;
	logic [4:0] hdr_i;
	logic [13:0] remain, wr_addr;
	logic [6:0] csum, top_bits;
	logic [2:0] pk_pos;
	logic kind_ok;
	logic [6:0] b;
	assign b = RX_BYTE_IN[6:0];

	function automatic logic number_ok(input logic [6:0] kind, input logic [13:0] num);
		number_ok = (kind == `MMI_TYPE_SCENE && (num <= `MMI_SCENE_MAX || num == `MMI_NUM_CURRENT))
			|| (kind == `MMI_TYPE_SETUP && num == `MMI_NUM_CURRENT);
	endfunction : number_ok

	always_ff @(posedge CORE_CLK_IN) begin
		DUMP_WR_VALID_OUT <= 1'b0;
		DUMP_DONE_OUT <= 1'b0;
		DUMP_BAD_OUT <= 1'b0;
		DUMP_SEND_OUT <= 1'b0;
		if (rx_clear) begin
			sx_state <= SX_IDLE;
			sx_req <= 1'b0;
			hdr_i <= 5'h00;
			remain <= 14'h0000;
			csum <= 7'h00;
			top_bits <= 7'h00;
			pk_pos <= 3'h0;
			wr_addr <= 14'h0000;
			kind_ok <= 1'b0;
			DUMP_WR_OUT <= '0;
			DUMP_SEND_REQ_OUT <= '0;
		end else if (is_stat) begin
			sx_state <= (RX_BYTE_IN == `MMI_B_SYSEX) ? SX_MFR : SX_IDLE;
			if (RX_BYTE_IN == `MMI_B_EOX && sx_state == SX_END) begin
				if (sx_req && kind_ok) begin
					DUMP_SEND_OUT <= 1'b1;
					DUMP_SEND_REQ_OUT <= '{channel: RECEIVE_CHANNEL_IN, kind: DUMP_WR_OUT.kind,
						number: DUMP_WR_OUT.number};
				end else if (!sx_req) begin
					DUMP_DONE_OUT <= csum == 7'h00 && kind_ok;
					DUMP_BAD_OUT <= csum != 7'h00;
				end
			end
		end else if (PANEL_DUMP_IN) begin
			DUMP_SEND_OUT <= 1'b1;
			DUMP_SEND_REQ_OUT <= '{channel: TRANSMIT_CHANNEL_IN, kind: PANEL_DUMP_KIND_IN,
				number: PANEL_DUMP_NUM_IN};
		end
		if (RST_B_IN && is_data) begin
			case (sx_state)
				SX_MFR: sx_state <= (RX_BYTE_IN == MFR_CODE) ? SX_SUB : SX_SKIP;
				SX_SUB: begin
					sx_req <= b[6:4] == `MMI_SUB_REQ;
					sx_state <= (BULK_RX_EN_IN && b[3:0] == RECEIVE_CHANNEL_IN
						&& (b[6:4] == `MMI_SUB_REQ || b[6:4] == `MMI_SUB_DATA)) ? SX_FMT : SX_SKIP;
				end
				SX_FMT: begin
					sx_state <= (RX_BYTE_IN != `MMI_FMT_UNIV) ? SX_SKIP : (sx_req ? SX_BODY : SX_CNTH);
					hdr_i <= 5'h00;
					csum <= 7'h00;
					pk_pos <= 3'h0;
					wr_addr <= 14'h0000;
				end
				SX_CNTH: begin
					remain[13:7] <= b;
					sx_state <= SX_CNTL;
				end
				SX_CNTL: begin
					remain[6:0] <= b;
					sx_state <= SX_BODY;
				end
				SX_BODY: begin
					csum <= csum + b;
					remain <= remain - 14'h0001;
					if (!sx_req && remain == 14'h0001)
						sx_state <= SX_CSUM;
					if (hdr_i <= `MMI_HDR_CUR)
						hdr_i <= hdr_i + 5'h01;
					if (hdr_i < 5'(`MMI_MODEL_LEN) && b != MODEL_ID[8'(62 - 8 * hdr_i) -: 7])
						sx_state <= SX_SKIP;
					if (hdr_i == `MMI_HDR_TYPE)
						DUMP_WR_OUT.kind <= b;
					if (hdr_i == `MMI_HDR_TYPE + 5'h01)
						DUMP_WR_OUT.number[13:7] <= b;
					if (hdr_i == `MMI_HDR_NUML) begin
						DUMP_WR_OUT.number[6:0] <= b;
						kind_ok <= number_ok(DUMP_WR_OUT.kind, {DUMP_WR_OUT.number[13:7], b});
						if (sx_req)
							sx_state <= SX_END;
					end
					if (hdr_i > `MMI_HDR_CUR) begin
						// Seven data bytes ride under one leading byte of top bits
						pk_pos <= (pk_pos == `MMI_PACK_LEN) ? 3'h0 : pk_pos + 3'h1;
						if (pk_pos == 3'h0) begin
							top_bits <= b;
						end else if (kind_ok) begin
							DUMP_WR_VALID_OUT <= 1'b1;
							DUMP_WR_OUT.data <= {top_bits[3'(`MMI_PACK_LEN - pk_pos)], b};
							DUMP_WR_OUT.addr <= wr_addr;
							wr_addr <= wr_addr + 14'h0001;
						end
					end
				end
				SX_CSUM: begin
					csum <= (csum + b) & `MMI_CSUM_MASK;
					sx_state <= SX_END;
				end
				SX_END: sx_state <= SX_SKIP;
				default: begin
				end
			endcase
		end
	end
endmodule : mmi_interp

// ==== mmi_cfg.svh ====
// Constants of the MIDI message interpreter: status codes, controllers, dump layout, timing
`ifndef MMI_CFG_SVH
`define MMI_CFG_SVH
`define MMI_ST_NOTE_OFF 4'h8
`define MMI_ST_NOTE_ON 4'h9
`define MMI_ST_CTRL 4'hB
`define MMI_ST_PROG 4'hC
`define MMI_ST_CHPRESS 4'hD
`define MMI_B_SYSEX 8'hF0
`define MMI_B_SONGPOS 8'hF2
`define MMI_B_EOX 8'hF7
`define MMI_B_CLOCK 8'hF8
`define MMI_B_START 8'hFA
`define MMI_B_CONT 8'hFB
`define MMI_B_STOP 8'hFC
`define MMI_B_SENSE 8'hFE
`define MMI_B_RESET 8'hFF
`define MMI_CC_NRPN_LSB 7'h62
`define MMI_CC_NRPN_MSB 7'h63
`define MMI_CC_DATA_LSB 7'h26
`define MMI_CC_DATA_MSB 7'h06
`define MMI_CC_TAB_LO_MAX 7'h5F
`define MMI_CC_TAB_HI_MIN 7'h66
`define MMI_CC_TAB_HI_MAX 7'h77
`define MMI_SUB_DATA 3'h0
`define MMI_SUB_REQ 3'h2
`define MMI_FMT_UNIV 8'h7E
`define MMI_MODEL_LEN 4'h8
`define MMI_HDR_TYPE 5'h08
`define MMI_HDR_NUML 5'h0A
`define MMI_HDR_CUR 5'h0C
`define MMI_TYPE_SCENE 7'h6D
`define MMI_TYPE_SETUP 7'h53
`define MMI_SCENE_MAX 14'h0063
`define MMI_NUM_CURRENT 14'h0100
`define MMI_PACK_LEN 3'h7
`define MMI_CSUM_MASK 7'h7F
`define MMI_CLK_KHZ 40000
`define MMI_SENSE_MS 400
`define MMI_SENSE_CYCLES (`MMI_SENSE_MS * `MMI_CLK_KHZ)
`endif

// ==== mmi_pkg.sv ====
// Types shared by the MIDI message interpreter and its users
package mmi_pkg;
	typedef struct packed {
		logic on;
		logic [6:0] note;
		logic [6:0] velocity;
	} mmi_note_s;
	typedef struct packed {
		logic nrpn;
		logic [13:0] number;
		logic [13:0] value;
	} mmi_param_s;
	typedef struct packed {
		logic [6:0] kind;
		logic [13:0] number;
		logic [13:0] addr;
		logic [7:0] data;
	} mmi_dump_wr_s;
	typedef struct packed {
		logic [3:0] channel;
		logic [6:0] kind;
		logic [13:0] number;
	} mmi_dump_req_s;
	typedef enum logic [3:0] {
		SX_IDLE = 4'b0000,
		SX_MFR = 4'b0001,
		SX_SUB = 4'b0010,
		SX_FMT = 4'b0011,
		SX_CNTH = 4'b0100,
		SX_CNTL = 4'b0101,
		SX_BODY = 4'b0110,
		SX_CSUM = 4'b0111,
		SX_END = 4'b1000,
		SX_SKIP = 4'b1001
	} mmi_sx_e;
endpackage : mmi_pkg

// ==== mmi_interp_assertions.sv ====
// Concurrent checks on the MIDI message interpreter ports
`timescale 1ns/100ps
module mmi_chk #(
	parameter int SENSE_CYCLES = 50
) (
	// Clock, reset and streams
	input logic CORE_CLK_IN,
	input logic RST_B_IN,
	input logic [7:0] RX_BYTE_IN,
	input logic RX_VALID_IN,
	input logic [7:0] TX_BYTE_OUT,
	input logic TX_VALID_OUT,
	input logic TX_READY_IN,
	// Settings and requests
	input logic [3:0] RECEIVE_CHANNEL_IN,
	input logic [3:0] TRANSMIT_CHANNEL_IN,
	input logic TIME_REF_MIDI_IN,
	input logic PANEL_DUMP_IN,
	// Events
	input logic NOTE_VALID_OUT,
	input mmi_pkg::mmi_note_s NOTE_OUT,
	input logic CLOCK_TICK_OUT,
	input logic RELOCATE_OUT,
	input logic AUTOMIX_START_OUT,
	input logic AUTOMIX_RUN_OUT,
	input logic SENSE_TIMEOUT_OUT,
	input logic DUMP_DONE_OUT,
	input logic DUMP_SEND_OUT,
	input mmi_pkg::mmi_dump_req_s DUMP_SEND_REQ_OUT
);
	import mmi_pkg::*;
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// ====
	// Helpers
	int quiet;
	logic rx_f8;
	assign rx_f8 = RX_VALID_IN && RX_BYTE_IN == 8'hF8;
	// Saturates so a long idle stretch cannot wrap
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_B_IN || RX_VALID_IN) begin
			quiet <= 0;
		end else if (quiet < SENSE_CYCLES + 8) begin
			quiet <= quiet + 1;
		end
	end
	// ====
	// Properties
	a_tick_per_clock: assert property (CLOCK_TICK_OUT == $past(rx_f8))
		else $error("tick mismatch");
	a_start_on_clock: assert property (AUTOMIX_START_OUT |-> $past(rx_f8) && AUTOMIX_RUN_OUT && TIME_REF_MIDI_IN)
		else $error("bad start");
	a_run_rise_start: assert property ($rose(AUTOMIX_RUN_OUT) |-> AUTOMIX_START_OUT)
		else $error("run without start");
	a_stop_halts: assert property (TIME_REF_MIDI_IN && RX_VALID_IN && RX_BYTE_IN == 8'hFC |=> !AUTOMIX_RUN_OUT)
		else $error("stop ignored");
	a_relocate_ref: assert property (RELOCATE_OUT |-> TIME_REF_MIDI_IN)
		else $error("relocate off reference");
	a_zero_vel_off: assert property (NOTE_VALID_OUT && NOTE_OUT.velocity == 7'h00 |-> !NOTE_OUT.on)
		else $error("zero velocity on");
	a_sense_quiet: assert property (SENSE_TIMEOUT_OUT |-> quiet >= SENSE_CYCLES - 1 && quiet <= SENSE_CYCLES + 1)
		else $error("timeout early or late");
	a_panel_send: assert property (PANEL_DUMP_IN && !RX_VALID_IN |=> DUMP_SEND_OUT &&
		DUMP_SEND_REQ_OUT.channel == TRANSMIT_CHANNEL_IN)
		else $error("panel dump lost");
	a_request_chan: assert property (DUMP_SEND_OUT && !$past(PANEL_DUMP_IN) |->
		DUMP_SEND_REQ_OUT.channel == RECEIVE_CHANNEL_IN)
		else $error("request channel");
	a_tx_holds: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
		else $error("tx byte dropped");
	c_start: cover property (AUTOMIX_START_OUT);
	c_done: cover property (DUMP_DONE_OUT);
	c_sense: cover property (SENSE_TIMEOUT_OUT);
endmodule : mmi_chk
bind mmi_interp mmi_chk #(.SENSE_CYCLES(SENSE_CYCLES)) chk_u (.*);

// ==== mmi_peer.sv ====
// Model of the external MIDI receiver taking the outgoing byte stream
`timescale 1ns/100ps
module mmi_peer (
	// Clock and reset
	input logic clk_in,
	input logic rst_b_in,
	// Stream
	input logic [7:0] byte_in,
	input logic valid_in,
	output logic ready_out,
	// A slow peer takes a byte only every third cycle
	input logic slow_in
);
	logic [1:0] phase;
	logic [7:0] got[$];
	always_ff @(posedge clk_in) begin
		phase <= (!rst_b_in || phase == 2'h2) ? 2'h0 : phase + 2'h1;
	end
	assign ready_out = !slow_in || phase == 2'h2;
	always @(posedge clk_in) begin
		if (rst_b_in && valid_in && ready_out) begin
			got.push_back(byte_in);
		end
	end
endmodule : mmi_peer

// ==== tb.sv ====
// Self-checking bench for the MIDI message interpreter
`timescale 1ns/100ps
module tb;
	import mmi_pkg::*;
	localparam int SENSE = 50;
	// ====
	// Signals
	logic clk, rst_b, rx_v, tx_v, tx_r, slow, any, cc_rx, cc_tx, cc_echo, nrpn, pc_rx, pc_tx, pc_echo, bulk_en;
	logic mref, op, op_rdy, sc_rec, pct_wr, pd, note_v, par_v, scr_v, tick, reloc, am_st, am_rw, am_run, sto;
	logic wr_v, done, bad, snd;
	logic [7:0] rx_b, tx_b;
	logic [3:0] rch, tch;
	logic [6:0] sc_num, pct_p, pct_s, pd_k, scene;
	logic [13:0] pd_n, spos;
	mmi_param_s op_d, par;
	mmi_note_s note;
	mmi_dump_wr_s wr;
	mmi_dump_req_s sreq;
	int fails, total_checks, cyc, n_sto;
	logic [7:0] wq[$];
	mmi_interp #(.SENSE_CYCLES(SENSE)) dut_u (.CORE_CLK_IN(clk), .RST_B_IN(rst_b), .RX_BYTE_IN(rx_b), .RX_VALID_IN(rx_v),
		.TX_BYTE_OUT(tx_b), .TX_VALID_OUT(tx_v), .TX_READY_IN(tx_r), .RECEIVE_CHANNEL_IN(rch), .TRANSMIT_CHANNEL_IN(tch),
		.ANY_CHANNEL_ACCEPT_IN(any), .CC_RX_EN_IN(cc_rx), .CC_TX_EN_IN(cc_tx), .CC_ECHO_IN(cc_echo),
		.CC_NRPN_MODE_IN(nrpn), .PC_RX_EN_IN(pc_rx), .PC_TX_EN_IN(pc_tx), .PC_ECHO_IN(pc_echo), .BULK_RX_EN_IN(bulk_en),
		.TIME_REF_MIDI_IN(mref), .PARAM_OP_IN(op), .PARAM_OP_DATA_IN(op_d), .PARAM_OP_READY_OUT(op_rdy),
		.SCENE_RECALLED_IN(sc_rec), .SCENE_RECALLED_NUM_IN(sc_num), .PCT_WR_IN(pct_wr), .PCT_PROG_IN(pct_p),
		.PCT_SCENE_IN(pct_s), .PANEL_DUMP_IN(pd), .PANEL_DUMP_KIND_IN(pd_k), .PANEL_DUMP_NUM_IN(pd_n),
		.NOTE_VALID_OUT(note_v), .NOTE_OUT(note), .PARAM_VALID_OUT(par_v), .PARAM_OUT(par), .SCENE_RECALL_OUT(scr_v),
		.SCENE_OUT(scene), .CLOCK_TICK_OUT(tick), .RELOCATE_OUT(reloc), .SONG_POS_OUT(spos),
		.AUTOMIX_START_OUT(am_st), .AUTOMIX_REWIND_OUT(am_rw), .AUTOMIX_RUN_OUT(am_run), .SENSE_TIMEOUT_OUT(sto),
		.DUMP_WR_VALID_OUT(wr_v), .DUMP_WR_OUT(wr), .DUMP_DONE_OUT(done), .DUMP_BAD_OUT(bad), .DUMP_SEND_OUT(snd),
		.DUMP_SEND_REQ_OUT(sreq));
	mmi_peer peer_u (.clk_in(clk), .rst_b_in(rst_b), .byte_in(tx_b), .valid_in(tx_v), .ready_out(tx_r), .slow_in(slow));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wr_v) begin
			wq.push_back(wr.data);
		end
		if (sto) begin
			n_sto <= n_sto + 1;
		end
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end
	// ====
	// Shared tasks
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task rst();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		peer_u.got.delete();
	endtask : rst
	// One byte, answer visible on return
	task tx(input logic [7:0] b);
		@(posedge clk);
		rx_b <= b;
		rx_v <= 1'b1;
		@(posedge clk);
		rx_v <= 1'b0;
		#1;
	endtask : tx
	task send_q(input logic [7:0] q[$]);
		foreach (q[i]) begin
			tx(q[i]);
		end
	endtask : send_q
	task peer_is(input logic [7:0] e[$]);
		repeat (60) @(posedge clk);
		chk(peer_u.got.size(), e.size());
		foreach (e[i]) begin
			chk(peer_u.got[i], e[i]);
		end
		peer_u.got.delete();
	endtask : peer_is
	task opr(input logic [13:0] n, input logic [13:0] v);
		@(posedge clk);
		while (op_rdy !== 1'b1) begin
			@(posedge clk);
		end
		op <= 1'b1;
		op_d <= {1'b0, n, v};
		@(posedge clk);
		op <= 1'b0;
	endtask : opr
	task pct(input logic [6:0] p, input logic [6:0] s);
		@(posedge clk);
		pct_wr <= 1'b1;
		pct_p <= p;
		pct_s <= s;
		@(posedge clk);
		pct_wr <= 1'b0;
	endtask : pct
	// Scene 5 data frame with a timing clock inside
	task frame(input logic [7:0] sub, input logic [6:0] corrupt);
		logic [7:0] body[$];
		logic [6:0] cs;
		body = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h6D, 8'h00, 8'h05, 8'h00, 8'h00,
			8'h52, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
		cs = 7'h00;
		foreach (body[i]) begin
			cs = cs - body[i][6:0];
		end
		send_q('{8'hF0, 8'h3A, sub, 8'h7E, 8'h00, 8'd21});
		send_q(body[0:12]);
		tx(8'hF8);
		send_q(body[13:20]);
		send_q('{{1'b0, cs ^ corrupt}, 8'hF7});
	endtask : frame
	// ====
	// Scenarios
	task t_note();
		send_q('{8'h93, 8'h3C, 8'h40});
		chk({note_v, note}, {2'b11, 7'h3C, 7'h40});
		send_q('{8'h93, 8'h3C, 8'h00});
		chk({note_v, note}, {2'b10, 7'h3C, 7'h00});
		send_q('{8'h94, 8'h3C, 8'h40});
		chk(note_v, 1'b0);
	endtask : t_note
	task cc_try(input logic e, input logic a, input logic [7:0] st, input logic [6:0] cn, input logic ex);
		@(posedge clk);
		cc_rx <= e;
		any <= a;
		send_q('{st, {1'b0, cn}, 8'h55});
		chk({par_v, par.nrpn, par.value}, {ex, 1'b0, 14'h0055});
	endtask : cc_try
	task t_cc();
		logic [6:0] cn[7] = '{7'h00, 7'h5F, 7'h60, 7'h65, 7'h66, 7'h77, 7'h78};
		rst();
		foreach (cn[i]) begin
			cc_try(1'b1, 1'b0, 8'hB3, cn[i], cn[i] <= 7'h5F || cn[i] inside {[7'h66:7'h77]});
		end
		cc_try(1'b1, 1'b0, 8'hB4, 7'h07, 1'b0);
		cc_try(1'b1, 1'b1, 8'hB4, 7'h07, 1'b1);
		cc_try(1'b0, 1'b1, 8'hB3, 7'h07, 1'b0);
		cc_echo <= 1'b1;
		cc_try(1'b1, 1'b0, 8'hB3, 7'h07, 1'b1);
		peer_is('{8'hB3, 8'h07, 8'h55});
		@(posedge clk);
		cc_echo <= 1'b0;
		nrpn <= 1'b1;
		send_q('{8'hB3, 8'h62, 8'h05, 8'hB3, 8'h63, 8'h01, 8'hB3, 8'h26, 8'h11});
		chk({par_v, par}, {2'b11, 14'h0085, 14'h0011});
		send_q('{8'hB3, 8'h06, 8'h02});
		chk({par_v, par}, {2'b11, 14'h0085, 14'h0111});
	endtask : t_cc
	task t_tx();
		rst();
		cc_tx <= 1'b1;
		nrpn <= 1'b0;
		opr(14'h0007, 14'h0040);
		peer_is('{8'hB5, 8'h07, 8'h40});
		nrpn <= 1'b1;
		opr(14'h0085, 14'h0111);
		peer_is('{8'hB5, 8'h62, 8'h05, 8'h63, 8'h01, 8'h26, 8'h11, 8'h06, 8'h02});
		opr(14'h0085, 14'h0011);
		peer_is('{8'hB5, 8'h62, 8'h05, 8'h63, 8'h01, 8'h26, 8'h11});
		cc_tx <= 1'b0;
		opr(14'h0007, 14'h0041);
		peer_is('{});
	endtask : t_tx
	task t_pc();
		rst();
		slow <= 1'b0;
		for (int p = 0; p < 128; p++) begin
			pct(7'(p), 7'(p) | 7'h40);
		end
		pct(7'h0A, 7'h04);
		pct(7'h03, 7'h04);
		pc_rx <= 1'b1;
		pc_echo <= 1'b1;
		send_q('{8'hC3, 8'h0A});
		chk({scr_v, scene}, {1'b1, 7'h04});
		peer_is('{8'hC3, 8'h0A});
		pc_rx <= 1'b0;
		pc_echo <= 1'b0;
		pc_tx <= 1'b1;
		sc_rec <= 1'b1;
		sc_num <= 7'h04;
		@(posedge clk);
		sc_rec <= 1'b0;
		repeat (140) @(posedge clk);
		peer_is('{8'hC5, 8'h03});
		send_q('{8'hC3, 8'h0A});
		chk(scr_v, 1'b0);
	endtask : t_pc
	task t_xport();
		send_q('{8'hFA, 8'hF8});
		chk({tick, am_st, am_run}, 3'b100);
		mref <= 1'b1;
		tx(8'hFA);
		chk(am_st, 1'b0);
		tx(8'hF8);
		chk({tick, am_st, am_run, am_rw}, 4'hF);
		tx(8'hFC);
		chk(am_run, 1'b0);
		send_q('{8'hFB, 8'hF8});
		chk({am_st, am_run, am_rw}, 3'b110);
		send_q('{8'hFC, 8'hF2, 8'h10, 8'h02});
		chk({reloc, spos}, {1'b1, 14'h0110});
	endtask : t_xport
	task t_sense();
		rst();
		cc_rx <= 1'b1;
		nrpn <= 1'b0;
		send_q('{8'hB3, 8'h07, 8'hF8, 8'h22});
		chk({par_v, par.value}, {1'b1, 14'h0022});
		send_q('{8'h07, 8'h23});
		chk(par_v, 1'b1);
		send_q('{8'hFF, 8'h07, 8'h24});
		chk(par_v, 1'b0);
		n_sto = 0;
		repeat (SENSE + 10) @(posedge clk);
		send_q('{8'hB3, 8'h07, 8'h25, 8'hFE});
		chk(n_sto, 0);
		repeat (SENSE + 10) @(posedge clk);
		chk(n_sto, 1);
		send_q('{8'h07, 8'h26});
		chk(par_v, 1'b0);
	endtask : t_sense
	task t_bulk();
		logic [7:0] d[7] = '{8'h81, 8'h02, 8'h83, 8'h04, 8'h05, 8'h86, 8'h07};
		rst();
		bulk_en <= 1'b1;
		wq.delete();
		frame(8'h03, 7'h00);
		chk({done, bad, wr.kind, wr.number}, {2'b10, 7'h6D, 14'h0005});
		chk(wq.size(), 7);
		foreach (d[i]) begin
			chk(wq[i], d[i]);
		end
		frame(8'h03, 7'h01);
		chk({done, bad}, 2'b01);
		wq.delete();
		frame(8'h04, 7'h00);
		chk(done, 1'b0);
		chk(wq.size(), 0);
		send_q('{8'hF0, 8'h3A, 8'h23, 8'h7E, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
			8'h6D, 8'h02, 8'h00, 8'hF7});
		chk({snd, sreq}, {1'b1, 4'h3, 7'h6D, 14'h0100});
		@(posedge clk);
		pd <= 1'b1;
		pd_k <= 7'h53;
		pd_n <= 14'h0100;
		@(posedge clk);
		pd <= 1'b0;
		#1;
		chk({snd, sreq}, {1'b1, 4'h5, 7'h53, 14'h0100});
	endtask : t_bulk
	initial begin
		{rst_b, rx_v, any, cc_rx, cc_tx, cc_echo, nrpn, pc_rx, pc_tx, pc_echo, bulk_en, mref, op, sc_rec, pct_wr, pd} = '0;
		{rx_b, op_d, sc_num, pct_p, pct_s, pd_k, pd_n, cyc, n_sto, fails, total_checks} = '0;
		rch = 4'h3;
		tch = 4'h5;
		slow = 1'b1;
		rst();
		t_note();
		t_cc();
		t_tx();
		t_pc();
		t_xport();
		t_sense();
		t_bulk();
		print_verdict();
	end
endmodule : tb
